// [rtl/txe_indicator.sv]
// Transmit error indicator with parity substitution and self-test progress.
// Assumes inputs synchronous to CLK, one character per clock.
//
// The register offsets and the AXI4-Lite register port were decided locally.
`timescale 1ns/10ps
module txe_indicator (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic [3:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [3:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire txe_pkg::txe_char_t TX_CHAR_IN,
	input wire logic TX_ODD_PARITY_IN,
	input wire logic PAB_UNDERFLOW,
	input wire logic PAB_OVERFLOW,
	input wire logic WORD_SYNC_SENT,
	input wire logic TX_PHASE_RECENTER_N,
	output txe_pkg::txe_char_t TX_CHAR_OUT,
	output logic PAB_REALIGN_ALLOW,
	output logic TX_ERROR_FLAG,
	output logic IRQ
);
	import txe_pkg::*;

	// -----------------------------------------------------------------------
	// Register bus
	// -----------------------------------------------------------------------
	txe_cfg_t cfg_reg;
	logic [2:0] irq_stat_reg;
	logic [2:0] irq_mask_reg;
	logic aw_held_reg;
	logic w_held_reg;
	logic [3:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;
	logic wr_fire;
	logic [2:0] irq_clear;
	logic [31:0] rd_next;
	logic [1:0] rresp_next;
	logic [31:0] cfg_word;
	logic [31:0] strb_mask;

	assign S_AXI_AWREADY = !aw_held_reg;
	assign S_AXI_WREADY = !w_held_reg;
	assign S_AXI_BVALID = bvalid_reg;
	assign S_AXI_BRESP = bresp_reg;
	assign S_AXI_ARREADY = !rvalid_reg;
	assign S_AXI_RVALID = rvalid_reg;
	assign S_AXI_RDATA = rdata_reg;
	assign S_AXI_RRESP = rresp_reg;
	assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;

	generate
		for (genvar i = 0; i < 4; i++) begin : g_strb
			assign strb_mask[8*i+7:8*i] = {8{wstrb_reg[i]}};
		end
	endgenerate

	assign cfg_word = (32'(cfg_reg) & ~strb_mask) | (wdata_reg & strb_mask);
	assign irq_clear = (wr_fire && awaddr_reg == OFS_IRQ_STAT && wstrb_reg[0])
		? wdata_reg[2:0] : 3'h0;

	// Address and data may arrive in either order
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= 4'h0;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
		end else begin
			if (S_AXI_AWVALID && !aw_held_reg) begin
				aw_held_reg <= 1'b1;
				awaddr_reg <= S_AXI_AWADDR;
			end else if (wr_fire) begin
				aw_held_reg <= 1'b0;
			end
			if (S_AXI_WVALID && !w_held_reg) begin
				w_held_reg <= 1'b1;
				wdata_reg <= S_AXI_WDATA;
				wstrb_reg <= S_AXI_WSTRB;
			end else if (wr_fire) begin
				w_held_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_reg <= 1'b1;
			bresp_reg <= (awaddr_reg == OFS_CTRL || awaddr_reg == OFS_IRQ_STAT
				|| awaddr_reg == OFS_IRQ_MASK) ? RESP_OKAY : RESP_SLVERR;
		end else if (S_AXI_BREADY) begin
			bvalid_reg <= 1'b0;
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			cfg_reg <= txe_cfg_t'(CTRL_RESET[CFG_W-1:0]);
			irq_mask_reg <= MASK_RESET;
		end else if (wr_fire) begin
			if (awaddr_reg == OFS_CTRL) begin
				cfg_reg <= txe_cfg_t'(cfg_word[CFG_W-1:0]);
			end
			if (awaddr_reg == OFS_IRQ_MASK && wstrb_reg[0]) begin
				irq_mask_reg <= wdata_reg[2:0];
			end
		end
	end

	// -----------------------------------------------------------------------
	// Parity check and substitution
	// -----------------------------------------------------------------------
	logic par_enable;
	logic ctrl_in_parity;
	logic par_error;
	logic par_flag_reg;
	txe_char_t char_out_reg;

	assign par_enable = cfg_reg.parity_check_control != LEV_LOW;
	// Control bits are data bits only when the encoder is bypassed
	assign ctrl_in_parity = !cfg_reg.tx_operating_mode_field[1];
	assign par_error = par_enable && !(^{TX_CHAR_IN.data, TX_ODD_PARITY_IN,
		ctrl_in_parity & ^TX_CHAR_IN.tx_char_control});

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			par_flag_reg <= 1'b0;
			char_out_reg <= txe_char_t'(10'h000);
		end else begin
			par_flag_reg <= par_error;
			char_out_reg <= par_error ? txe_char_t'(BAD_CHAR_CODE)
				: TX_CHAR_IN;
		end
	end

	a_par_flag_one: assert property (@(posedge CLK) disable iff (!RESET_N)
		par_error ##1 !par_error |-> par_flag_reg ##1 !par_flag_reg)
		else $error("parity flag not one period");
	a_par_sub_char: assert property (@(posedge CLK) disable iff (!RESET_N)
		par_error |=> TX_CHAR_OUT == txe_char_t'(BAD_CHAR_CODE))
		else $error("bad character not substituted");
	a_par_flag_off: assert property (@(posedge CLK) disable iff (!RESET_N)
		!par_enable |=> !par_flag_reg)
		else $error("parity flag with checking off");

	// -----------------------------------------------------------------------
	// Self-test pass counter
	// -----------------------------------------------------------------------
	logic with_sync;
	logic long_pulse;
	logic [9:0] pass_len;
	logic [9:0] char_cnt_reg;
	logic [4:0] pulse_cnt_reg;
	logic pass_end;
	logic bist_flag;

	// Sync appended only with local receive clock and a mode other than LL
	assign with_sync = cfg_reg.rx_clock_source_select == LEV_LOW
		&& cfg_reg.tx_operating_mode_field != MODE_LL;
	assign long_pulse = cfg_reg.rx_clock_source_select != LEV_MID
		&& cfg_reg.tx_operating_mode_field != MODE_LL;
	assign pass_len = with_sync ? PASS_CHARS + SYNC_CHARS : PASS_CHARS;
	assign pass_end = cfg_reg.bist_enable && char_cnt_reg == pass_len - 10'h001;
	assign bist_flag = pulse_cnt_reg != 5'h00;

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			char_cnt_reg <= 10'h000;
		end else if (!cfg_reg.bist_enable || pass_end) begin
			char_cnt_reg <= 10'h000;
		end else begin
			char_cnt_reg <= char_cnt_reg + 10'h001;
		end
	end

	// Pulse length latched at pass end, a mode change mid-pulse is ignored
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			pulse_cnt_reg <= 5'h00;
		end else if (!cfg_reg.bist_enable) begin
			pulse_cnt_reg <= 5'h00;
		end else if (pass_end) begin
			pulse_cnt_reg <= long_pulse ? PULSE_LONG : PULSE_SHORT;
		end else if (bist_flag) begin
			pulse_cnt_reg <= pulse_cnt_reg - 5'h01;
		end
	end

	// Run length of the pass pulse, held against the length latched at pass end
	logic [4:0] hi_run_reg;
	logic long_sel_reg;

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			hi_run_reg <= 5'h00;
			long_sel_reg <= 1'b0;
		end else begin
			hi_run_reg <= bist_flag ? hi_run_reg + 5'h01 : 5'h00;
			if (pass_end) begin
				long_sel_reg <= long_pulse;
			end
		end
	end

	a_bist_short_pulse: assert property (@(posedge CLK) disable iff (!RESET_N)
		pass_end && !long_pulse |=> bist_flag ##1 !bist_flag)
		else $error("short pass pulse wrong length");
	a_bist_long_pulse: assert property (@(posedge CLK) disable iff (!RESET_N)
		$fell(bist_flag) && cfg_reg.bist_enable && long_sel_reg
		|-> hi_run_reg == PULSE_LONG)
		else $error("long pass pulse wrong length");
	a_bist_pass_len: assert property (@(posedge CLK) disable iff (!RESET_N)
		pass_end |-> char_cnt_reg == (with_sync ? 10'h20E : 10'h1FE))
		else $error("pass length wrong");

	// -----------------------------------------------------------------------
	// Phase-align buffer fault
	// -----------------------------------------------------------------------
	logic pab_active;
	logic pab_event;
	logic pab_clear;
	logic pab_fault_reg;

	assign pab_active = cfg_reg.tx_clock_source_select != LEV_LOW
		|| cfg_reg.tx_half_rate_select;
	assign pab_event = pab_active && (PAB_UNDERFLOW || PAB_OVERFLOW);
	assign pab_clear = WORD_SYNC_SENT || !TX_PHASE_RECENTER_N;
	// Realign permitted only while recentring reset is held low
	assign PAB_REALIGN_ALLOW = !TX_PHASE_RECENTER_N;

	// A new fault in the clearing cycle wins
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			pab_fault_reg <= 1'b0;
		end else if (pab_event) begin
			pab_fault_reg <= 1'b1;
		end else if (pab_clear) begin
			pab_fault_reg <= 1'b0;
		end
	end

	a_pab_hold_flag: assert property (@(posedge CLK) disable iff (!RESET_N)
		pab_fault_reg && !pab_clear |=> pab_fault_reg && TX_ERROR_FLAG)
		else $error("buffer fault dropped early");
	a_pab_recenter_clr: assert property (@(posedge CLK) disable iff (!RESET_N)
		!TX_PHASE_RECENTER_N && !pab_event |=> !pab_fault_reg)
		else $error("buffer fault not cleared");

	// -----------------------------------------------------------------------
	// Error flag and interrupts
	// -----------------------------------------------------------------------
	logic flag_reg;
	logic [2:0] irq_events;

	// Single character-rate clock; half-rate dual-edge timing is upstream
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			flag_reg <= 1'b0;
		end else begin
			// Self-test term drops with the enable, as the pulse counter does
			flag_reg <= par_error || (cfg_reg.bist_enable && (pass_end
				|| (bist_flag && pulse_cnt_reg != PULSE_SHORT)))
				|| pab_event
				|| (pab_fault_reg && !pab_clear);
		end
	end

	assign TX_ERROR_FLAG = flag_reg;
	assign TX_CHAR_OUT = char_out_reg;

	a_flag_or_sources: assert property (@(posedge CLK) disable iff (!RESET_N)
		TX_ERROR_FLAG == (par_flag_reg || bist_flag || pab_fault_reg))
		else $error("flag is not the OR of sources");

	assign irq_events[IRQ_PARITY] = par_error;
	assign irq_events[IRQ_PASS] = pass_end;
	assign irq_events[IRQ_PAB] = pab_event;

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			irq_stat_reg <= 3'h0;
		end else begin
			irq_stat_reg <= (irq_stat_reg & ~irq_clear) | irq_events;
		end
	end

	assign IRQ = |(irq_stat_reg & irq_mask_reg);

	a_irq_set_wins: assert property (@(posedge CLK) disable iff (!RESET_N)
		irq_events[IRQ_PARITY] |=> irq_stat_reg[IRQ_PARITY])
		else $error("interrupt event lost");

	// -----------------------------------------------------------------------
	// Register read
	// -----------------------------------------------------------------------
	always_comb begin
		rd_next = 32'h0000_0000;
		rresp_next = RESP_OKAY;
		case (S_AXI_ARADDR)
			OFS_CTRL: rd_next = 32'(cfg_reg);
			OFS_STATE: rd_next = {12'h000, char_cnt_reg, pulse_cnt_reg,
				pab_active, pab_fault_reg, bist_flag, par_flag_reg, flag_reg};
			OFS_IRQ_STAT: rd_next = {29'h0, irq_stat_reg};
			OFS_IRQ_MASK: rd_next = {29'h0, irq_mask_reg};
			default: rresp_next = RESP_SLVERR;
		endcase
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= RESP_OKAY;
		end else if (S_AXI_ARVALID && !rvalid_reg) begin
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_next;
			rresp_reg <= rresp_next;
		end else if (S_AXI_RREADY) begin
			rvalid_reg <= 1'b0;
		end
	end

	a_axi_wr_resp: assert property (@(posedge CLK) disable iff (!RESET_N)
		wr_fire |=> S_AXI_BVALID && S_AXI_AWREADY)
		else $error("write response missing");
endmodule

// [rtl/txe_pkg.sv]
// Constants, field layouts and carrier types of the transmit error indicator.
// Assumes a 20 MHz character-rate clock and an AXI4-Lite register master.
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
package txe_pkg;
	// -----------------------------------------------------------------------
	// Register map
	// -----------------------------------------------------------------------
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_STATE = 4'h4;
	localparam logic [3:0] OFS_IRQ_STAT = 4'h8;
	localparam logic [3:0] OFS_IRQ_MASK = 4'hC;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [2:0] MASK_RESET = 3'h0;
	// -----------------------------------------------------------------------
	// Three-level select encodings
	// -----------------------------------------------------------------------
	localparam logic [1:0] LEV_LOW = 2'h0;
	localparam logic [1:0] LEV_MID = 2'h1;
	localparam logic [1:0] LEV_HIGH = 2'h2;
	localparam logic [1:0] MODE_LL = 2'h0;
	// -----------------------------------------------------------------------
	// Self-test timing in characters
	// -----------------------------------------------------------------------
	localparam logic [9:0] PASS_CHARS = 10'h1FF;
	localparam logic [9:0] SYNC_CHARS = 10'h010;
	localparam logic [4:0] PULSE_SHORT = 5'h01;
	localparam logic [4:0] PULSE_LONG = 5'h11;
	// Forced-bad code image, arbitrary plain default
	localparam logic [9:0] BAD_CHAR_CODE = 10'h0E7;
	// Interrupt bit positions
	localparam int IRQ_PARITY = 0;
	localparam int IRQ_PASS = 1;
	localparam int IRQ_PAB = 2;
	// Control register layout, low bits
	typedef struct packed {
		logic bist_enable;
		logic tx_half_rate_select;
		logic [1:0] tx_operating_mode_field;
		logic [1:0] tx_clock_source_select;
		logic [1:0] rx_clock_source_select;
		logic [1:0] parity_check_control;
	} txe_cfg_t;
	localparam int CFG_W = 10;
	// Character as captured from the host
	typedef struct packed {
		logic [1:0] tx_char_control;
		logic [7:0] data;
	} txe_char_t;
endpackage

// [tb/txe_host_model.sv]
// Host-side character source for the transmit error indicator.
// Assumes the bench changes its requests just after rising CLK.
`timescale 1ns/10ps
module txe_host_model (
	input wire logic [7:0] data,
	input wire logic [1:0] ctrl,
	input wire logic bypass,
	input wire logic bad,
	output txe_pkg::txe_char_t char_out,
	output logic parity_out
);
	import txe_pkg::*;
	// -------------------------------------------------------------------
	// Odd parity, control bits included only when the encoder is bypassed
	// -------------------------------------------------------------------
	always_comb begin
		char_out = {ctrl, data};
		parity_out = ~(^data ^ (bypass & ^ctrl)) ^ bad;
	end
endmodule

// [tb/txe_indicator_tb.sv]
// Self-checking bench for the transmit error indicator.
// Assumes an AXI4-Lite slave and one character per CLK.
`timescale 1ns/10ps
module txe_indicator_tb;
	import txe_pkg::*;
	logic CLK = 0, reset_n = 0, awvalid = 0, wvalid = 0, bready = 0;
	logic arvalid = 0, rready = 0, bypass = 0, bad = 0;
	logic unf = 0, ovf = 0, wsync = 0, recenter_n = 1;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
	logic [31:0] wdata = 32'h0;
	logic [7:0] c_data = 8'h00;
	logic [1:0] c_ctrl = 2'h1;
	logic awready, wready, bvalid, arready, rvalid, tx_par, realign;
	logic flag, irq;
	logic [1:0] bresp, rresp, wr_resp;
	logic [31:0] rdata;
	txe_char_t tx_char, char_out;
	int failures = 0, samples_checked = 0, cycles = 0;
	txe_host_model txe_host_model_i (.data(c_data), .ctrl(c_ctrl),
		.bypass(bypass), .bad(bad), .char_out(tx_char),
		.parity_out(tx_par));
	txe_indicator txe_indicator_i (.CLK(CLK), .RESET_N(reset_n),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
		.S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
		.S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .TX_CHAR_IN(tx_char),
		.TX_ODD_PARITY_IN(tx_par), .PAB_UNDERFLOW(unf), .PAB_OVERFLOW(ovf),
		.WORD_SYNC_SENT(wsync), .TX_PHASE_RECENTER_N(recenter_n),
		.TX_CHAR_OUT(char_out), .PAB_REALIGN_ALLOW(realign),
		.TX_ERROR_FLAG(flag), .IRQ(irq));
	// -------------------------------------------------------------------
	// Clock, watchdog, reporting
	// -------------------------------------------------------------------
	always #25 CLK = ~CLK;
	task automatic conclude();
		$display("failures %0d samples_checked %0d", failures, samples_checked);
		if (failures == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Ceiling well above the five self-test runs of two passes each
	always @(posedge CLK) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			$display("[ERR] %0t watchdog expired", $time);
			conclude();
		end
	end
	task automatic check1(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t flag got %b exp %b", $time, got, exp);
		end
	endtask
	task automatic check32(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t word got %h exp %h", $time, got, exp);
		end
	endtask
	// -------------------------------------------------------------------
	// Bus and stimulus tasks
	// -------------------------------------------------------------------
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
		logic aw_ok;
		logic w_ok;
		aw_ok = 0;
		w_ok = 0;
		@(posedge CLK);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (!(aw_ok && w_ok)) begin
			@(posedge CLK);
			if (!aw_ok && awready === 1'b1) begin
				aw_ok = 1;
				awvalid <= 0;
			end
			if (!w_ok && wready === 1'b1) begin
				w_ok = 1;
				wvalid <= 0;
			end
		end
		do @(posedge CLK); while (bvalid !== 1'b1);
		wr_resp = bresp;
		bready <= 0;
	endtask
	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge CLK);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do begin
			@(posedge CLK);
			if (arready === 1'b1) arvalid <= 0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 0;
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(a, d, r);
		check32(d, e);
	endtask
	function automatic logic [31:0] mk(input logic b, h,
		input logic [1:0] m, t, r, p);
		txe_cfg_t c;
		c = {b, h, m, t, r, p};
		return {22'h0, c};
	endfunction
	task automatic send(input logic [7:0] d, input logic b);
		@(posedge CLK);
		c_data <= d;
		bad <= b;
	endtask
	task automatic chk_char(input logic f, input logic [9:0] e);
		#1;
		check1(flag, f);
		check32({22'h0, char_out}, {22'h0, e});
	endtask
	// Buffer event: 0 underflow, 1 overflow, 2 word sync sent
	task automatic ev(input int k);
		@(posedge CLK);
		unf <= (k == 0);
		ovf <= (k == 1);
		wsync <= (k == 2);
		@(posedge CLK);
		{unf, ovf, wsync} <= 3'h0;
		#1;
	endtask
	task automatic bist(input logic [1:0] r, m, input int per, w);
		int n;
		axi_wr(OFS_CTRL, mk(0, 0, m, LEV_LOW, r, LEV_LOW));
		axi_wr(OFS_CTRL, mk(1, 0, m, LEV_LOW, r, LEV_LOW));
		do @(posedge CLK); while (flag !== 1'b1);
		n = 0;
		while (flag === 1'b1) begin
			@(posedge CLK);
			n++;
		end
		check32(n, w);
		while (flag !== 1'b1) begin
			@(posedge CLK);
			n++;
		end
		check32(n, per);
	endtask
	// -------------------------------------------------------------------
	// Main sequence
	// -------------------------------------------------------------------
	initial begin
		repeat (10) @(posedge CLK);
		reset_n <= 1;
		rd_chk(OFS_CTRL, CTRL_RESET);
		rd_chk(OFS_IRQ_MASK, {29'h0, MASK_RESET});
		rd_chk(4'h2, 32'h0);
		check32({30'h0, rresp}, {30'h0, RESP_SLVERR});
		axi_wr(OFS_STATE, 32'h0);
		check32({30'h0, wr_resp}, {30'h0, RESP_SLVERR});
		axi_wr(OFS_CTRL, mk(0, 0, 2'h2, LEV_LOW, LEV_MID, LEV_MID));
		check32({30'h0, wr_resp}, {30'h0, RESP_OKAY});
		// Byte strobe: only the low byte may land
		wstrb <= 4'h1;
		axi_wr(OFS_CTRL, 32'hFFFF_FF85);
		wstrb <= 4'hF;
		rd_chk(OFS_CTRL, 32'h0000_0085);
		send(8'h5A, 0);
		send(8'hC3, 1);
		chk_char(0, {c_ctrl, 8'h5A});
		send(8'h3C, 1);
		chk_char(1, BAD_CHAR_CODE);
		send(8'h96, 0);
		chk_char(1, BAD_CHAR_CODE);
		send(8'h69, 0);
		chk_char(0, {c_ctrl, 8'h96});
		check1(irq, 0);
		axi_wr(OFS_IRQ_MASK, 32'h7);
		#1 check1(irq, 1);
		axi_wr(OFS_IRQ_STAT, 32'h1);
		#1 check1(irq, 0);
		axi_wr(OFS_CTRL, mk(0, 0, MODE_LL, LEV_LOW, LEV_MID, LEV_MID));
		bypass <= 1;
		send(8'h11, 0);
		send(8'h22, 1);
		chk_char(0, {c_ctrl, 8'h11});
		send(8'h33, 0);
		chk_char(1, BAD_CHAR_CODE);
		axi_wr(OFS_CTRL, mk(0, 0, 2'h2, LEV_LOW, LEV_MID, LEV_LOW));
		bypass <= 0;
		send(8'h44, 1);
		send(8'h55, 0);
		chk_char(0, {c_ctrl, 8'h44});
		rd_chk(OFS_IRQ_STAT, 32'h1);
		axi_wr(OFS_IRQ_STAT, 32'h1);
		ev(0);
		check1(flag, 0);
		axi_wr(OFS_CTRL, mk(0, 0, 2'h2, LEV_MID, LEV_MID, LEV_LOW));
		ev(1);
		check1(flag, 1);
		repeat (20) @(posedge CLK);
		#1 check1(flag, 1);
		ev(2);
		check1(flag, 0);
		@(posedge CLK);
		#1 check1(flag, 0);
		axi_wr(OFS_CTRL, mk(0, 1, 2'h2, LEV_LOW, LEV_MID, LEV_LOW));
		ev(0);
		check1(flag, 1);
		@(posedge CLK);
		recenter_n <= 0;
		#1 check1(realign, 1);
		repeat (2) @(posedge CLK);
		#1 check1(flag, 0);
		@(posedge CLK);
		recenter_n <= 1;
		#1 check1(realign, 0);
		rd_chk(OFS_IRQ_STAT, 32'h4);
		check1(irq, 1);
		bist(LEV_MID, 2'h2, 511, 1);
		bist(LEV_LOW, 2'h2, 527, 17);
		bist(LEV_HIGH, 2'h2, 511, 17);
		bist(LEV_LOW, MODE_LL, 511, 1);
		bist(LEV_HIGH, MODE_LL, 511, 1);
		conclude();
	end
endmodule
